/* hw/bst_pkg.sv */
// Purpose: Shared constants and types for the boundary-scan test port.
// Assumes: The test clock runs the scan registers; the system clock runs the boundary cell outputs.
// Notes: Scan bit 1 is held in bit 0 of the scan vectors.
//
// Summary of operation
// - Serial output is driven only in shift-instruction or shift-data; high impedance otherwise.
// - Shift-instruction places the instruction register between serial input and output.
// - Asynchronous test reset forces the controller straight into test-logic-reset.
// - Code 1111 is BYPASS and is the instruction in effect after reset.
// - Code 0010 is SAMPLE/PRELOAD: boundary register scanned, chip operation undisturbed.
// - Code 0000 is EXTEST: boundary register scanned and driven on the pins; run-test/idle also samples pins.
// - Code 1001 is HIGHZ: all outputs off, bypass register on the serial path.
// - Code 1100 is CLAMP: outputs held from boundary register, bypass on serial path.
// - BYPASS puts exactly one stage between serial input and output in shift-data.
// - The boundary register is 62 bits over all functional pins, none of the test pins.
// - Capture-data loads the pin states; shift-data then shifts the boundary register.
// - Boundary bit 1, shifted out first, is the match output-enable pin.
// - Scan registers run on the test clock; the boundary cell outputs update on the functional clock.
// - Mode select and data in sampled on rising edge; data out changes on falling.
// - Five rising edges with mode select high reach test-logic-reset.
// - Undriven mode select or serial data input reads as logic 1.

package bst_pkg;

  localparam int BST_BSR_LEN = 62;
  localparam int BST_IR_W = 4;

  localparam logic [BST_IR_W-1:0] BST_IR_BYPASS = 4'hF;
  localparam logic [BST_IR_W-1:0] BST_IR_SAMPLE = 4'h2;
  localparam logic [BST_IR_W-1:0] BST_IR_EXTEST = 4'h0;
  localparam logic [BST_IR_W-1:0] BST_IR_HIGHZ = 4'h9;
  localparam logic [BST_IR_W-1:0] BST_IR_CLAMP = 4'hC;
  // Fixed pattern loaded into the instruction shifter in capture-instruction.
  localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 4'h1;
  localparam logic [BST_IR_W-1:0] BST_IR_RESET = BST_IR_BYPASS;

  localparam logic [BST_BSR_LEN-1:0] BST_BSR_RESET = '0;
  localparam logic BST_BIT_RESET = 1'b0;

  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SHIFT_DR = 4'h4,
    ST_EXIT1_DR = 4'h5,
    ST_PAUSE_DR = 4'h6,
    ST_EXIT2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'hA,
    ST_SHIFT_IR = 4'hB,
    ST_EXIT1_IR = 4'hC,
    ST_PAUSE_IR = 4'hD,
    ST_EXIT2_IR = 4'hE,
    ST_UPD_IR = 4'hF
  } bst_tap_state_type;

endpackage

/* hw/bst_test_port.sv */
// Purpose: Boundary-scan test access port with a 62-bit boundary register.
// Assumes: Pads pull the mode select and serial data inputs high when undriven.
// Notes: Update data and mode levels cross into the system clock domain for the boundary cells.

`timescale 1ns/1ns

module bst_test_port
  import bst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic trst_b,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BST_BSR_LEN-1:0] core_out,
  input wire logic [BST_BSR_LEN-1:0] core_oe,
  input wire logic [BST_BSR_LEN-1:0] pin_in,
  output logic [BST_BSR_LEN-1:0] pin_out,
  output logic [BST_BSR_LEN-1:0] pin_oe
);

  // Test clock domain state.
  bst_tap_state_type state_r;
  bst_tap_state_type state_nxt;
  logic [BST_IR_W-1:0] ir_sh_r;
  logic [BST_IR_W-1:0] ir_sh_nxt;
  logic [BST_IR_W-1:0] ir_r;
  logic [BST_IR_W-1:0] ir_nxt;
  logic byp_r;
  logic byp_nxt;
  logic [BST_BSR_LEN-1:0] bsr_r;
  logic [BST_BSR_LEN-1:0] bsr_nxt;
  logic [BST_BSR_LEN-1:0] upd_r;
  logic [BST_BSR_LEN-1:0] upd_nxt;
  logic upd_tgl_r;
  logic upd_tgl_nxt;
  logic [BST_BSR_LEN-1:0] pin_s1_r;
  logic [BST_BSR_LEN-1:0] pin_s2_r;
  logic mode_drv_r;
  logic mode_hiz_r;
  logic tdo_r;
  logic tdo_oe_r;

  // System clock domain state.
  logic drv_s1_r;
  logic drv_s2_r;
  logic hiz_s1_r;
  logic hiz_s2_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic [BST_BSR_LEN-1:0] upd_sys_r;
  logic [BST_BSR_LEN-1:0] upd_sys_nxt;
  logic [BST_BSR_LEN-1:0] pin_out_r;
  logic [BST_BSR_LEN-1:0] pin_oe_r;

  // Controller state decodes.
  wire in_tlr = (state_r == ST_TLR);
  wire in_rti = (state_r == ST_RTI);
  wire in_cap_dr = (state_r == ST_CAP_DR);
  wire in_shift_dr = (state_r == ST_SHIFT_DR);
  wire in_upd_dr = (state_r == ST_UPD_DR);
  wire in_cap_ir = (state_r == ST_CAP_IR);
  wire in_shift_ir = (state_r == ST_SHIFT_IR);
  wire in_upd_ir = (state_r == ST_UPD_IR);

  // Instruction decodes; anything unlisted falls to the bypass path.
  wire op_sample = (ir_r == BST_IR_SAMPLE);
  wire op_extest = (ir_r == BST_IR_EXTEST);
  wire op_highz = (ir_r == BST_IR_HIGHZ);
  wire op_clamp = (ir_r == BST_IR_CLAMP);
  wire bsr_sel = op_sample | op_extest;
  wire drive_mode = op_extest | op_clamp;

  // Pin samples used by capture: synchronised copies of the pads.
  wire bsr_capture = (in_cap_dr & bsr_sel) | (in_rti & op_extest);
  wire bsr_shift = in_shift_dr & bsr_sel;

  // Serial output selection; bit 1 of the chain leaves first.
  wire dr_serial = bsr_sel ? bsr_r[0] : byp_r;
  wire tdo_mux = in_shift_ir ? ir_sh_r[0] : dr_serial;
  wire tdo_active = in_shift_ir | in_shift_dr;

  // Boundary-cell update handshake as seen from the system clock.
  wire upd_arrived = tgl_s2_r ^ tgl_s3_r;

  // Standard sixteen-state controller steered by mode select.
  // The pads pull an undriven mode select or data input high, so it reads as 1.
  always_comb
  begin
    case (state_r)
      ST_TLR: state_nxt = tms ? ST_TLR : ST_RTI;
      ST_RTI: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_nxt = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_nxt = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      // Select-IR with mode select high is the step that, after five
      // high edges from anywhere, lands the controller in reset.
      ST_SEL_IR: state_nxt = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_nxt = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_nxt = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      default: state_nxt = ST_TLR;
    endcase
  end

  // Instruction shifter and the instruction in effect.
  assign ir_sh_nxt = in_cap_ir ? BST_IR_CAPTURE :
                     in_shift_ir ? {tdi, ir_sh_r[BST_IR_W-1:1]} : ir_sh_r;
  assign ir_nxt = in_tlr ? BST_IR_BYPASS :
                  in_upd_ir ? ir_sh_r : ir_r;

  // Single bypass stage.
  assign byp_nxt = in_cap_dr ? 1'b0 :
                   in_shift_dr ? tdi : byp_r;

  // Boundary register: capture pins, shift towards bit 1.
  assign bsr_nxt = bsr_capture ? pin_s2_r :
                   bsr_shift ? {tdi, bsr_r[BST_BSR_LEN-1:1]} : bsr_r;

  // The update stage only moves while the boundary register is selected,
  // so CLAMP holds whatever was preloaded.
  wire upd_load = in_upd_dr & bsr_sel;
  assign upd_nxt = upd_load ? bsr_r : upd_r;
  assign upd_tgl_nxt = upd_load ? ~upd_tgl_r : upd_tgl_r;

  // Controller: asynchronous test reset wins immediately.
  always_ff @(posedge tck or negedge trst_b)
  begin
    if (!trst_b)
    begin
      state_r <= ST_TLR;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Instruction path.
  always_ff @(posedge tck or negedge trst_b)
  begin
    if (!trst_b)
    begin
      ir_sh_r <= BST_IR_RESET;
      ir_r <= BST_IR_RESET;
    end
    else
    begin
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
    end
  end

  // Data registers, all on the test clock.
  always_ff @(posedge tck or negedge trst_b)
  begin
    if (!trst_b)
    begin
      byp_r <= BST_BIT_RESET;
      bsr_r <= BST_BSR_RESET;
      upd_r <= BST_BSR_RESET;
      upd_tgl_r <= BST_BIT_RESET;
    end
    else
    begin
      byp_r <= byp_nxt;
      bsr_r <= bsr_nxt;
      upd_r <= upd_nxt;
      upd_tgl_r <= upd_tgl_nxt;
    end
  end

  // Pads, the functional clock pad among them, are sampled through two
  // test-clock stages, so a capture sees the pins two edges late.
  always_ff @(posedge tck or negedge trst_b)
  begin
    if (!trst_b)
    begin
      pin_s1_r <= BST_BSR_RESET;
      pin_s2_r <= BST_BSR_RESET;
    end
    else
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Mode levels are registered before they cross so that no decode
  // glitch reaches the other domain.
  always_ff @(posedge tck or negedge trst_b)
  begin
    if (!trst_b)
    begin
      mode_drv_r <= BST_BIT_RESET;
      mode_hiz_r <= BST_BIT_RESET;
    end
    else
    begin
      mode_drv_r <= drive_mode;
      mode_hiz_r <= op_highz;
    end
  end

  // Serial output moves on the falling edge.
  always_ff @(negedge tck or negedge trst_b)
  begin
    if (!trst_b)
    begin
      tdo_r <= BST_BIT_RESET;
      tdo_oe_r <= BST_BIT_RESET;
    end
    else
    begin
      tdo_r <= tdo_mux;
      tdo_oe_r <= tdo_active;
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // System clock side: synchronisers for the mode levels and the toggle.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      drv_s1_r <= BST_BIT_RESET;
      drv_s2_r <= BST_BIT_RESET;
      hiz_s1_r <= BST_BIT_RESET;
      hiz_s2_r <= BST_BIT_RESET;
      tgl_s1_r <= BST_BIT_RESET;
      tgl_s2_r <= BST_BIT_RESET;
      tgl_s3_r <= BST_BIT_RESET;
    end
    else
    begin
      drv_s1_r <= mode_drv_r;
      drv_s2_r <= drv_s1_r;
      hiz_s1_r <= mode_hiz_r;
      hiz_s2_r <= hiz_s1_r;
      tgl_s1_r <= upd_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // The update word is held for at least four test clocks after its toggle,
  // far longer than the three system clocks needed to see the toggle.
  assign upd_sys_nxt = upd_arrived ? upd_r : upd_sys_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      upd_sys_r <= BST_BSR_RESET;
    end
    else
    begin
      upd_sys_r <= upd_sys_nxt;
    end
  end

  // Boundary cells: test data replaces core data only in drive modes, and
  // HIGHZ overrides every output enable.
  genvar gi;
  generate
    for (gi = 0; gi < BST_BSR_LEN; gi = gi + 1)
    begin : g_cell
      wire cell_out = drv_s2_r ? upd_sys_r[gi] : core_out[gi];
      wire cell_oe = hiz_s2_r ? 1'b0 :
                     drv_s2_r ? 1'b1 : core_oe[gi];
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
        begin
          pin_out_r[gi] <= BST_BIT_RESET;
          pin_oe_r[gi] <= BST_BIT_RESET;
        end
        else
        begin
          pin_out_r[gi] <= cell_out;
          pin_oe_r[gi] <= cell_oe;
        end
      end
    end
  endgenerate

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;

endmodule

/* testbench/bst_test_port_checker.sv */
// Purpose: Concurrent checks on the test port pins.
// Assumes: Only the top module ports are visible here.
// Notes: Shift states are inferred from tms and tdo_oe.
`timescale 1ns/1ns
module bst_test_port_checker
  import bst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic trst_b,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [BST_BSR_LEN-1:0] core_out,
  input wire logic [BST_BSR_LEN-1:0] core_oe,
  input wire logic [BST_BSR_LEN-1:0] pin_out,
  input wire logic [BST_BSR_LEN-1:0] pin_oe
);
  sequence five_high;
    tms [*5];
  endsequence
  sequence leave_shift;
    tdo_oe && tms;
  endsequence
  tms_reset_a: assert property (@(posedge tck) disable iff (!trst_b)
    five_high |=> !tdo_oe) else $error("tdo enabled after five tms highs");
  oe_enter_a: assert property (@(posedge tck) disable iff (!trst_b)
    $rose(tdo_oe) |-> !$past(tms) && !$past(tms, 2)) else $error("tdo enabled off shift");
  oe_hold_a: assert property (@(posedge tck) disable iff (!trst_b)
    tdo_oe && !tms |=> tdo_oe) else $error("tdo released inside shift");
  oe_exit_a: assert property (@(posedge tck) disable iff (!trst_b)
    leave_shift |=> !tdo_oe) else $error("tdo still driven after shift");
  oe_fall_a: assert property (@(posedge tck) disable iff (!trst_b)
    $fell(tdo_oe) |-> $past(tms)) else $error("tdo released without tms high");
  trst_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !trst_b |=> !tdo_oe) else $error("tdo driven under test reset");
  tdo_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tck && $past(tck) && trst_b && $past(trst_b) |-> $stable(tdo))
    else $error("tdo moved while tck high");
  core_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !trst_b [*6] |=> pin_out == $past(core_out) && pin_oe == $past(core_oe))
    else $error("pins not following core in reset");
endmodule
bind bst_test_port bst_test_port_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .tck(tck), .trst_b(trst_b), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
  .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

/* testbench/bst_tester.sv */
// Purpose: Board-test controller model on the far side of the link.
// Assumes: One call of step is one tck period of 48 ns.
// Notes: tck stands low between calls.
`timescale 1ns/1ns
module bst_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic tms_d = 1'b1;
  logic tdi_d = 1'b1;
  logic en_d = 1'b0;
  // A released line reads high through the pad pull-up.
  assign tms = en_d ? tms_d : 1'b1;
  assign tdi = en_d ? tdi_d : 1'b1;
  initial tck = 1'b0;
  // Lines move after the falling edge; tdo is taken at the rising edge.
  task automatic step(input logic m, input logic d, input logic en, output logic q,
    output logic qe);
    tms_d = m;
    tdi_d = d;
    en_d = en;
    #12 tck = 1'b1;
    q = tdo;
    qe = tdo_oe;
    #24 tck = 1'b0;
    #12;
  endtask
endmodule

/* testbench/tb.sv */
// Purpose: Self-checking bench for the boundary-scan test port.
// Assumes: The tester model makes tck only while it moves the controller.
// Notes: Pin vectors change on clk_sys rising edges only.
`timescale 1ns/1ns
module tb import bst_pkg::*;;
  logic clk_sys, rst_b, trst_b, tck, tms, tdi, tdo, tdo_oe, q, qe;
  logic [BST_BSR_LEN-1:0] core_out, core_oe, pin_in, pin_out, pin_oe, q_vec;
  int n_mismatch = 0;
  int checked = 0;
  localparam logic [BST_BSR_LEN-1:0] PV = 62'h2AAA_5555_F0F0_1234;
  localparam logic [BST_BSR_LEN-1:0] QV = 62'h1234_5678_9ABC_DEF0;
  localparam logic [BST_BSR_LEN-1:0] RV = 62'h3C3C_0FF0_A5A5_6789;
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  bst_test_port u_bst_test_port (.clk_sys(clk_sys), .rst_b(rst_b), .tck(tck),
    .trst_b(trst_b), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  bst_tester u_bst_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [BST_BSR_LEN-1:0] got, input logic [BST_BSR_LEN-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic m, input logic d);
    u_bst_tester.step(m, d, 1'b1, q, qe);
  endtask
  // Shifts n bits from the shift state, then passes update into run-test/idle.
  task automatic scan(input int n, input logic [BST_BSR_LEN-1:0] din);
    q_vec = '0;
    for (int i = 0; i < n; i++)
    begin
      go(i == n - 1, din[i]);
      q_vec[i] = q;
      check(qe, 1'b1);
    end
    go(1'b1, 1'b1);
    go(1'b0, 1'b1);
  endtask
  task automatic ir(input logic [BST_IR_W-1:0] code);
    go(1'b1, 1'b1);
    go(1'b1, 1'b1);
    go(1'b0, 1'b1);
    go(1'b0, 1'b1);
    scan(BST_IR_W, code);
    check(q_vec, BST_IR_CAPTURE);
    // The mode registers only see the new instruction at the next test clock.
    go(1'b0, 1'b1);
  endtask
  task automatic dr(input int n, input logic [BST_BSR_LEN-1:0] din);
    go(1'b1, 1'b1);
    go(1'b0, 1'b1);
    go(1'b0, 1'b1);
    scan(n, din);
  endtask
  // One stage: the captured zero leads, then the first bit sent.
  task automatic byp;
    dr(2, 62'h1);
    check(q_vec, 62'h2);
  endtask
  task automatic pins(input logic [BST_BSR_LEN-1:0] pi, input logic [BST_BSR_LEN-1:0] co);
    @(posedge clk_sys);
    pin_in <= pi;
    core_out <= co;
    repeat (10) @(posedge clk_sys);
    #2;
  endtask
  task automatic t_reset;
    @(posedge clk_sys);
    trst_b <= 1'b0;
    repeat (10) @(posedge clk_sys);
    trst_b <= 1'b1;
    repeat (6) u_bst_tester.step(1'b0, 1'b0, 1'b0, q, qe);
    go(1'b0, 1'b1);
    byp();
  endtask
  task automatic t_sample;
    ir(4'h5);
    byp();
    pins(PV, RV);
    ir(BST_IR_SAMPLE);
    dr(BST_BSR_LEN, QV);
    check(q_vec, PV);
    check(pin_out, RV);
    check(pin_oe, core_oe);
  endtask
  task automatic t_extest;
    pins(RV, PV);
    ir(BST_IR_EXTEST);
    pins(RV, PV);
    check(pin_out, QV);
    check(pin_oe, '1);
    dr(BST_BSR_LEN, QV);
    check(q_vec, RV);
  endtask
  task automatic t_clamp_highz;
    ir(BST_IR_CLAMP);
    pins(PV, ~PV);
    check(pin_out, QV);
    byp();
    check(pin_out, QV);
    ir(BST_IR_HIGHZ);
    pins(PV, RV);
    check(pin_oe, '0);
    byp();
    ir(BST_IR_BYPASS);
    pins(PV, QV);
    check(pin_out, QV);
    check(pin_oe, core_oe);
  endtask
  // Test reset in the middle of a data shift must drop tdo and restore BYPASS.
  task automatic t_trst;
    ir(BST_IR_SAMPLE);
    go(1'b1, 1'b1);
    go(1'b0, 1'b1);
    go(1'b0, 1'b1);
    check(tdo_oe, 1'b1);
    @(posedge clk_sys);
    trst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #2;
    check(tdo_oe, 1'b0);
    @(posedge clk_sys);
    trst_b <= 1'b1;
    @(posedge clk_sys);
    go(1'b0, 1'b1);
    byp();
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    rst_b = 1'b0;
    trst_b = 1'b0;
    pin_in = '0;
    core_out = '0;
    core_oe = 62'h0F0F_3333_AAAA_5555;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_sample();
    t_extest();
    t_clamp_highz();
    t_trst();
    tally_and_finish();
  end
endmodule
